// file: sdbrw_ctrl.sv
// memory controller end: link clock, spacing checks and burst transfer
// Summary of operation
// RULE1 - select line low chops, high gives eight
// RULE2 - chopped column commands spaced four clocks apart
// RULE3 - select line never part of column address
// RULE4 - each column command may request auto precharge
// RULE5 - field 00, or 01 with high: eight
// RULE6 - field 01 with select low: chopped four
// RULE7 - read to precharge waits additive plus internal
// RULE8 - internal delay at least max(4, 7.5ns)
// RULE9 - activate to precharge minimum also respected
// RULE10 - reactivate after precharge period and row cycle
// RULE11 - any timing violation needs full reinitialisation
// RULE12 - setup/hold slip corrupts only that burst
// RULE13 - strobe slip corrupts only that burst
// RULE14 - every strobe edge of burst meets timing
// RULE15 - read data after additive plus column latency
// RULE16 - precharge before opening another row
// RULE17 - per-bank counters and one shared column counter check every spacing
`timescale 1ns/1ps
module sdbrw_ctrl #(
  parameter int RP_CK  = sdbrw_pkg::RP_CK,
  parameter int RAS_CK = sdbrw_pkg::RAS_CK,
  parameter int RC_CK  = sdbrw_pkg::RC_CK
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  sdbrw_link_if.ctrl       LINK,
  input  wire logic        REQ_VALID,
  input  wire logic [2:0]  REQ_CMD,
  input  wire logic [2:0]  REQ_BANK,
  input  wire logic [15:0] REQ_ROW,
  input  wire logic [9:0]  REQ_COL,
  input  wire logic        REQ_CHOP,
  input  wire logic        REQ_AUTO_PRE,
  input  wire logic [63:0] REQ_WDATA,
  input  wire logic [1:0]  MODE_BURST,
  input  wire logic [3:0]  ADD_LAT,
  input  wire logic [3:0]  WR_LAT,
  output logic             REQ_READY,
  output logic             REQ_REFUSED,
  output logic             RD_VALID,
  output logic [63:0]      RD_DATA
);
  if (RP_CK < 1 || RAS_CK < 1 || RC_CK < 1 || RC_CK > 250) begin : g_chk
    $error("spacing counts must lie in 1..250 link cycles");
  end

  typedef enum logic [4:0] {
    C_IDLE  = 5'h01,
    C_ISSUE = 5'h02,
    C_WLAT  = 5'h04,
    C_WBEAT = 5'h08,
    C_RBEAT = 5'h10
  } sdbrw_cst_t;

  // ages saturate so a long quiet spell never wraps back to "recent"
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction

  // link clock divider
  logic [3:0]  div_q, div_d;
  logic        ck_q, ck_d;
  logic        tick, rise_en, fall_en;

  // per-bank ages in link cycles, open flags and the shared column age
  logic [7:0]  act_age_q [sdbrw_pkg::BANKS];
  logic [7:0]  act_age_d [sdbrw_pkg::BANKS];
  logic [7:0]  rd_age_q  [sdbrw_pkg::BANKS];
  logic [7:0]  rd_age_d  [sdbrw_pkg::BANKS];
  logic [7:0]  pre_age_q [sdbrw_pkg::BANKS];
  logic [7:0]  pre_age_d [sdbrw_pkg::BANKS];
  logic [7:0]  open_q, open_d;
  logic [7:0]  col_age_q, col_age_d;

  // request and transfer state
  sdbrw_cst_t  st_q, st_d;
  logic [2:0]  p_cmd_q, p_cmd_d, p_bank_q, p_bank_d;
  logic [15:0] p_row_q, p_row_d;
  logic [9:0]  p_col_q, p_col_d;
  logic        p_chop_q, p_chop_d, p_apc_q, p_apc_d;
  logic [63:0] p_wd_q, p_wd_d, rd_q, rd_d;
  logic [3:0]  bl_q, bl_d, beat_q, beat_d;
  logic [4:0]  lat_q, lat_d;
  logic        rdy_q, rdy_d, ref_q, ref_d, rv_q, rv_d;

  // link outputs
  logic [2:0]  cmd_q, cmd_d, bank_q, bank_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0]  dq_q, dq_d;
  logic        dqoe_q, dqoe_d, dqs_q, dqs_d, dqsoe_q, dqsoe_d, pend_q, pend_d;

  // read strobe and data sampled from the pins
  logic [8:0]  rs1_q, rs2_q;
  logic        rs3_q;
  logic        dqs_edge, ok;
  logic [7:0]  wl;
  logic [7:0]  rd_pre_min;

  assign tick     = (div_q == 4'(sdbrw_pkg::CK_HALF_SYS - 1));
  assign rise_en  = tick & ~ck_q;
  assign fall_en  = tick & ck_q;
  assign dqs_edge = rs2_q[8] ^ rs3_q;
  assign wl       = 8'(WR_LAT);
  assign rd_pre_min = 8'(ADD_LAT) + 8'(sdbrw_pkg::RTP_CK);  // see RULE7 see RULE8

  // spacing check for the pending command against per-bank ages and the shared column age  see RULE17
  always_comb begin
    ok = 1'b1;
    unique case (p_cmd_q)
      sdbrw_pkg::CMD_ACT: begin
        // closed bank, precharge period and row cycle both elapsed  see RULE10 see RULE16
        ok = !open_q[p_bank_q] && pre_age_q[p_bank_q] >= 8'(RP_CK)
             && act_age_q[p_bank_q] >= 8'(RC_CK);
      end
      sdbrw_pkg::CMD_PRE: begin
        ok = rd_age_q[p_bank_q] >= rd_pre_min  // see RULE7
             && act_age_q[p_bank_q] >= 8'(RAS_CK);  // see RULE9
      end
      sdbrw_pkg::CMD_RD, sdbrw_pkg::CMD_WR: begin
        ok = open_q[p_bank_q] && col_age_q >= 8'(sdbrw_pkg::COL_GAP_CK);  // see RULE2
      end
      default: ok = 1'b1;
    endcase
  end

  // next state of divider, counters, request engine and link pins
  always_comb begin
    div_d  = tick ? 4'h0 : div_q + 4'h1;
    ck_d   = tick ? ~ck_q : ck_q;
    act_age_d = act_age_q;
    rd_age_d  = rd_age_q;
    pre_age_d = pre_age_q;
    open_d    = open_q;
    col_age_d = col_age_q;
    if (rise_en) begin
      for (int i = 0; i < sdbrw_pkg::BANKS; i++) begin
        act_age_d[i] = sat_inc(act_age_q[i]);
        rd_age_d[i]  = sat_inc(rd_age_q[i]);
        pre_age_d[i] = sat_inc(pre_age_q[i]);
      end
      col_age_d = sat_inc(col_age_q);
    end
    st_d = st_q;
    p_cmd_d = p_cmd_q; p_bank_d = p_bank_q; p_row_d = p_row_q; p_col_d = p_col_q;
    p_chop_d = p_chop_q; p_apc_d = p_apc_q; p_wd_d = p_wd_q;
    bl_d = bl_q; beat_d = beat_q; lat_d = lat_q; rd_d = rd_q;
    rdy_d = rdy_q; ref_d = 1'b0; rv_d = 1'b0;
    cmd_d = cmd_q; bank_d = bank_q; addr_d = addr_q;
    dq_d = dq_q; dqoe_d = dqoe_q; dqsoe_d = dqsoe_q; pend_d = 1'b0;
    dqs_d = pend_q ? ~dqs_q : dqs_q;
    // a command occupies one link cycle, fall to fall
    if (fall_en) cmd_d = sdbrw_pkg::CMD_NOP;
    unique case (st_q)
      C_IDLE: begin
        if (REQ_VALID) begin
          p_cmd_d = REQ_CMD; p_bank_d = REQ_BANK; p_row_d = REQ_ROW; p_col_d = REQ_COL;
          p_chop_d = REQ_CHOP; p_apc_d = REQ_AUTO_PRE; p_wd_d = REQ_WDATA;
          rdy_d = 1'b0;
          st_d  = C_ISSUE;
        end
      end
      C_ISSUE: begin
        if (fall_en) begin
          rdy_d = 1'b1;
          st_d  = C_IDLE;
          // nothing that breaks a spacing reaches the device  see RULE11
          if (!ok) begin
            ref_d = 1'b1;
          end else begin
            cmd_d  = p_cmd_q;
            bank_d = p_bank_q;
            addr_d = p_row_q;
            unique case (p_cmd_q)
              sdbrw_pkg::CMD_ACT: begin
                act_age_d[p_bank_q] = 8'h00;
                open_d[p_bank_q]    = 1'b1;
              end
              sdbrw_pkg::CMD_PRE: begin
                pre_age_d[p_bank_q] = 8'h00;
                open_d[p_bank_q]    = 1'b0;
              end
              sdbrw_pkg::CMD_RD, sdbrw_pkg::CMD_WR: begin
                // column bits, auto precharge flag and select line apart  see RULE3 see RULE4
                addr_d = {6'h00, p_col_q};
                addr_d[sdbrw_pkg::APC_BIT]  = p_apc_q;
                addr_d[sdbrw_pkg::CHOP_BIT] = ~p_chop_q;  // see RULE1
                bl_d   = sdbrw_pkg::burst_beats(MODE_BURST, ~p_chop_q);  // see RULE5 see RULE6
                beat_d = 4'h0;
                lat_d  = 5'h00;
                col_age_d = 8'h00;
                rdy_d  = 1'b0;
                if (p_cmd_q == sdbrw_pkg::CMD_RD) begin
                  rd_age_d[p_bank_q] = 8'h00;
                  st_d = C_RBEAT;
                end else begin
                  st_d = C_WLAT;
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
      C_WLAT: begin
        if (rise_en) begin
          if (8'(lat_q) == wl) st_d = C_WBEAT;
          else lat_d = lat_q + 5'h01;
        end
      end
      C_WBEAT: begin
        // each beat held a whole link cycle, strobe one system cycle after data  see RULE14
        if (fall_en) begin
          if (beat_q == bl_q) begin
            dqoe_d  = 1'b0;
            dqsoe_d = 1'b0;
            dqs_d   = 1'b0;
            rdy_d   = 1'b1;
            st_d    = C_IDLE;
            if (p_apc_q) begin
              open_d[p_bank_q]    = 1'b0;  // see RULE4
              pre_age_d[p_bank_q] = 8'h00;
            end
          end else begin
            dq_d    = p_wd_q[beat_q[2:0]*8 +: 8];
            dqoe_d  = 1'b1;
            dqsoe_d = 1'b1;
            pend_d  = 1'b1;
            beat_d  = beat_q + 4'h1;
          end
        end
      end
      C_RBEAT: begin
        // beats arrive on device strobe edges after its read latency  see RULE15
        if (dqs_edge) begin
          rd_d[beat_q[2:0]*8 +: 8] = rs2_q[7:0];
          beat_d = beat_q + 4'h1;
          if (beat_q + 4'h1 == bl_q) begin
            rv_d  = 1'b1;
            rdy_d = 1'b1;
            st_d  = C_IDLE;
            if (p_apc_q) begin
              open_d[p_bank_q]    = 1'b0;  // see RULE4
              pre_age_d[p_bank_q] = 8'h00;
            end
          end
        end
      end
      default: st_d = C_IDLE;
    endcase
  end

  // registers only; strobe and data from the pins pass two flops
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      div_q <= 4'h0; ck_q <= 1'b0;
      act_age_q <= '{default: sdbrw_pkg::AGE_RST};
      rd_age_q  <= '{default: sdbrw_pkg::AGE_RST};
      pre_age_q <= '{default: sdbrw_pkg::AGE_RST};
      open_q <= 8'h00; col_age_q <= sdbrw_pkg::AGE_RST;
      st_q <= C_IDLE;
      p_cmd_q <= sdbrw_pkg::CMD_NOP; p_bank_q <= 3'h0; p_row_q <= 16'h0000; p_col_q <= 10'h000;
      p_chop_q <= 1'b0; p_apc_q <= 1'b0; p_wd_q <= '0; rd_q <= '0;
      bl_q <= sdbrw_pkg::BEATS_FULL; beat_q <= 4'h0; lat_q <= 5'h00;
      rdy_q <= 1'b1; ref_q <= 1'b0; rv_q <= 1'b0;
      cmd_q <= sdbrw_pkg::CMD_NOP; bank_q <= 3'h0; addr_q <= 16'h0000;
      dq_q <= 8'h00; dqoe_q <= 1'b0; dqs_q <= 1'b0; dqsoe_q <= 1'b0; pend_q <= 1'b0;
      rs1_q <= 9'h000; rs2_q <= 9'h000; rs3_q <= 1'b0;
    end else begin
      div_q <= div_d; ck_q <= ck_d;
      act_age_q <= act_age_d; rd_age_q <= rd_age_d; pre_age_q <= pre_age_d;
      open_q <= open_d; col_age_q <= col_age_d;
      st_q <= st_d;
      p_cmd_q <= p_cmd_d; p_bank_q <= p_bank_d; p_row_q <= p_row_d; p_col_q <= p_col_d;
      p_chop_q <= p_chop_d; p_apc_q <= p_apc_d; p_wd_q <= p_wd_d; rd_q <= rd_d;
      bl_q <= bl_d; beat_q <= beat_d; lat_q <= lat_d;
      rdy_q <= rdy_d; ref_q <= ref_d; rv_q <= rv_d;
      cmd_q <= cmd_d; bank_q <= bank_d; addr_q <= addr_d;
      dq_q <= dq_d; dqoe_q <= dqoe_d; dqs_q <= dqs_d; dqsoe_q <= dqsoe_d; pend_q <= pend_d;
      rs1_q <= {LINK.dqs, LINK.dq};
      rs2_q <= rs1_q;
      rs3_q <= rs2_q[8];
    end
  end

  assign LINK.ck          = ck_q;
  assign LINK.cmd         = cmd_q;
  assign LINK.bank        = bank_q;
  assign LINK.addr        = addr_q;
  assign LINK.ctrl_dq_o   = dq_q;
  assign LINK.ctrl_dq_oe  = dqoe_q;
  assign LINK.ctrl_dqs_o  = dqs_q;
  assign LINK.ctrl_dqs_oe = dqsoe_q;
  assign REQ_READY        = rdy_q;
  assign REQ_REFUSED      = ref_q;
  assign RD_VALID         = rv_q;
  assign RD_DATA          = rd_q;
endmodule

// file: sdbrw_pkg.sv
// shared constants, command codes and burst length decode for both link ends
package sdbrw_pkg;
  localparam int BANKS    = 8;
  localparam int BANK_W   = 3;
  localparam int ADDR_W   = 16;
  localparam int DQ_W     = 8;
  localparam int BEATS_W  = 4;
  localparam int CHOP_BIT = 12;
  localparam int APC_BIT  = 10;

  // command codes on the link
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ACT = 3'h1;
  localparam logic [2:0] CMD_RD  = 3'h2;
  localparam logic [2:0] CMD_WR  = 3'h3;
  localparam logic [2:0] CMD_PRE = 3'h4;

  // burst field of mode_register_zero
  localparam logic [1:0] MODE_FIXED8 = 2'h0;
  localparam logic [1:0] MODE_OTF    = 2'h1;
  localparam logic [1:0] MODE_FIXED4 = 2'h2;

  localparam logic [3:0] BEATS_CHOP = 4'h4;
  localparam logic [3:0] BEATS_FULL = 4'h8;

  // link clock made by the controller: half period in system cycles
  localparam int CK_HALF_SYS = 8;
  localparam int SYS_PS      = 10000;
  localparam int CK_PS       = 2 * CK_HALF_SYS * SYS_PS;

  // spacing figures in link clock cycles, but for RTP_MIN_PS in picoseconds
  localparam int COL_GAP_CK  = 4;
  localparam int RTP_MIN_CK  = 4;
  localparam int RTP_MIN_PS  = 7500;
  localparam int RTP_PS_CK   = (RTP_MIN_PS + CK_PS - 1) / CK_PS;
  localparam int RTP_CK      = (RTP_PS_CK > RTP_MIN_CK) ? RTP_PS_CK : RTP_MIN_CK;
  localparam int RP_CK       = 4;
  localparam int RAS_CK      = 6;
  localparam int RC_CK       = 10;
  localparam logic [7:0] AGE_RST = 8'hff;

  // beats of one burst from the mode field and the chop select line
  function automatic logic [3:0] burst_beats(input logic [1:0] mode, input logic sel);
    logic [3:0] b;
    b = BEATS_FULL;
    if (mode == MODE_FIXED4 || (mode == MODE_OTF && !sel)) begin
      b = BEATS_CHOP;
    end
    return b;
  endfunction
endpackage

// file: sdbrw_link_if.sv
// link between memory controller and memory device, with wire resolution
`timescale 1ns/1ps
interface sdbrw_link_if;
  logic        ck;
  logic [2:0]  cmd;
  logic [2:0]  bank;
  logic [15:0] addr;
  logic [7:0]  ctrl_dq_o;
  logic        ctrl_dq_oe;
  logic        ctrl_dqs_o;
  logic        ctrl_dqs_oe;
  logic [7:0]  dev_dq_o;
  logic        dev_dq_oe;
  logic        dev_dqs_o;
  logic        dev_dqs_oe;
  logic [7:0]  dq;
  logic        dqs;

  // bus level from the enables; an undriven bus reads low
  assign dq  = dev_dq_oe ? dev_dq_o : (ctrl_dq_oe ? ctrl_dq_o : 8'h00);
  assign dqs = dev_dqs_oe ? dev_dqs_o : (ctrl_dqs_oe ? ctrl_dqs_o : 1'b0);

  modport ctrl (output ck, cmd, bank, addr, ctrl_dq_o, ctrl_dq_oe, ctrl_dqs_o, ctrl_dqs_oe,
                input dq, dqs);
  modport dev  (input ck, cmd, bank, addr, dq, dqs,
                output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe);
endinterface

// file: sdbrw_dev.sv
// memory device end: command decode, burst engine and small array
`timescale 1ns/1ps
module sdbrw_dev #(
  parameter int COL_BITS = 3
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  sdbrw_link_if.dev       LINK,
  input  wire logic [1:0] MODE_BURST,
  input  wire logic [3:0] ADD_LAT,
  input  wire logic [3:0] CAS_LAT,
  output logic [7:0]      OPEN_BANKS,
  output logic            BUSY
);
  localparam int WORDS = sdbrw_pkg::BANKS << COL_BITS;
  localparam int SW    = 32;

  if (COL_BITS < 3) begin : g_chk
    $error("COL_BITS must cover a full burst of eight");
  end

  typedef enum logic [3:0] {
    D_IDLE  = 4'h1,
    D_RLAT  = 4'h2,
    D_RDATA = 4'h4,
    D_WDATA = 4'h8
  } sdbrw_dst_t;

  // sequential burst order, wrapping inside a four or eight beat window
  function automatic logic [COL_BITS+2:0] word_idx(input logic [2:0] bk,
                                                   input logic [COL_BITS-1:0] col,
                                                   input logic [3:0] beat,
                                                   input logic full);
    logic [COL_BITS-1:0] c;
    c = col;
    if (full) c[2:0] = col[2:0] + beat[2:0];
    else      c[1:0] = col[1:0] + beat[1:0];
    return {bk, c};
  endfunction

  logic [SW-1:0]        s1_q, s1_d, s2_q, s2_d;
  logic                 ck3_q, ck3_d, dqs3_q, dqs3_d;
  sdbrw_dst_t           st_q, st_d;
  logic [4:0]           lat_q, lat_d;
  logic [3:0]           beat_q, beat_d, bl_q, bl_d;
  logic [COL_BITS-1:0]  col_q, col_d;
  logic [2:0]           bk_q, bk_d;
  logic                 apc_q, apc_d, pend_q, pend_d, busy_q, busy_d;
  logic [7:0]           open_q, open_d;
  logic [7:0]           mem_q [WORDS];
  logic [7:0]           mem_d [WORDS];
  logic [7:0]           dq_q, dq_d;
  logic                 dqoe_q, dqoe_d, dqs_q, dqs_d, dqsoe_q, dqsoe_d;
  logic                 ck_rise, dqs_edge;
  logic [2:0]           l_cmd, l_bank;
  logic [15:0]          l_addr;
  logic [7:0]           l_dq;
  logic [4:0]           rl;

  // pins pass two flops; the second stage feeds logic, with a third flop on clock and strobe for edges
  assign l_cmd    = s2_q[29:27];
  assign l_bank   = s2_q[26:24];
  assign l_addr   = s2_q[23:8];
  assign l_dq     = s2_q[7:0];
  assign ck_rise  = s2_q[31] & ~ck3_q;
  assign dqs_edge = s2_q[30] ^ dqs3_q;
  assign rl       = 5'(ADD_LAT) + 5'(CAS_LAT);

  always_comb begin
    s1_d   = {LINK.ck, LINK.dqs, LINK.cmd, LINK.bank, LINK.addr, LINK.dq};
    s2_d   = s1_q;
    ck3_d  = s2_q[31];
    dqs3_d = s2_q[30];
    st_d   = st_q;
    lat_d  = lat_q;
    beat_d = beat_q;
    bl_d   = bl_q;
    col_d  = col_q;
    bk_d   = bk_q;
    apc_d  = apc_q;
    open_d = open_q;
    mem_d  = mem_q;
    dq_d   = dq_q;
    dqoe_d = dqoe_q;
    dqs_d  = dqs_q;
    dqsoe_d = dqsoe_q;
    pend_d = 1'b0;
    // strobe follows data by one cycle so the far end catches settled data
    if (pend_q) dqs_d = ~dqs_q;
    // write beats land only inside the addressed burst window  see RULE12 see RULE13
    if (st_q == D_WDATA && dqs_edge) begin
      mem_d[word_idx(bk_q, col_q, beat_q, bl_q[3])] = l_dq;
      beat_d = beat_q + 4'h1;
      if (beat_q + 4'h1 == bl_q) begin
        st_d = D_IDLE;
        if (apc_q) open_d[bk_q] = 1'b0;  // see RULE4
      end
    end
    if (ck_rise) begin
      unique case (st_q)
        D_RLAT: begin
          // first beat appears read_latency_total rises after the command  see RULE15
          if (lat_q == rl) begin
            dq_d    = mem_q[word_idx(bk_q, col_q, 4'h0, bl_q[3])];
            dqoe_d  = 1'b1;
            dqsoe_d = 1'b1;
            pend_d  = 1'b1;
            beat_d  = 4'h1;
            st_d    = D_RDATA;
          end else begin
            lat_d = lat_q + 5'h01;
          end
        end
        D_RDATA: begin
          if (beat_q == bl_q) begin
            dqoe_d  = 1'b0;
            dqsoe_d = 1'b0;
            dqs_d   = 1'b0;
            st_d    = D_IDLE;
            if (apc_q) open_d[bk_q] = 1'b0;  // see RULE4
          end else begin
            dq_d   = mem_q[word_idx(bk_q, col_q, beat_q, bl_q[3])];
            pend_d = 1'b1;
            beat_d = beat_q + 4'h1;
          end
        end
        default: begin
        end
      endcase
      // commands are taken when idle, or cut short a half-strobed write  see RULE13
      if (st_q == D_IDLE || st_q == D_WDATA) begin
        if (l_cmd == sdbrw_pkg::CMD_ACT) open_d[l_bank] = 1'b1;
        if (l_cmd == sdbrw_pkg::CMD_PRE) open_d[l_bank] = 1'b0;
        if ((l_cmd == sdbrw_pkg::CMD_RD || l_cmd == sdbrw_pkg::CMD_WR) && open_q[l_bank]) begin
          // chop select sets length only; the column comes from the low bits  see RULE3
          bl_d   = sdbrw_pkg::burst_beats(MODE_BURST, l_addr[sdbrw_pkg::CHOP_BIT]);  // see RULE1 see RULE5 see RULE6
          col_d  = l_addr[COL_BITS-1:0];
          bk_d   = l_bank;
          apc_d  = l_addr[sdbrw_pkg::APC_BIT];  // see RULE4
          beat_d = 4'h0;
          lat_d  = 5'h01;
          st_d   = (l_cmd == sdbrw_pkg::CMD_RD) ? D_RLAT : D_WDATA;
        end
      end
    end
    busy_d = (st_d != D_IDLE);
  end

  // registers only
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s1_q <= '0; s2_q <= '0; ck3_q <= 1'b0; dqs3_q <= 1'b0;
      st_q <= D_IDLE; lat_q <= 5'h00; beat_q <= 4'h0; bl_q <= sdbrw_pkg::BEATS_FULL;
      col_q <= '0; bk_q <= 3'h0; apc_q <= 1'b0; open_q <= 8'h00; pend_q <= 1'b0;
      mem_q <= '{default: 8'h00};
      dq_q <= 8'h00; dqoe_q <= 1'b0; dqs_q <= 1'b0; dqsoe_q <= 1'b0; busy_q <= 1'b0;
    end else begin
      s1_q <= s1_d; s2_q <= s2_d; ck3_q <= ck3_d; dqs3_q <= dqs3_d;
      st_q <= st_d; lat_q <= lat_d; beat_q <= beat_d; bl_q <= bl_d;
      col_q <= col_d; bk_q <= bk_d; apc_q <= apc_d; open_q <= open_d; pend_q <= pend_d;
      mem_q <= mem_d;
      dq_q <= dq_d; dqoe_q <= dqoe_d; dqs_q <= dqs_d; dqsoe_q <= dqsoe_d; busy_q <= busy_d;
    end
  end

  assign LINK.dev_dq_o   = dq_q;
  assign LINK.dev_dq_oe  = dqoe_q;
  assign LINK.dev_dqs_o  = dqs_q;
  assign LINK.dev_dqs_oe = dqsoe_q;
  assign OPEN_BANKS      = open_q;
  assign BUSY            = busy_q;
endmodule

// file: sdbrw_chk.sv
// link protocol checker between the controller and device ends
`timescale 1ns/1ps
module sdbrw_chk #(
  parameter int AL  = 1,
  parameter int CL  = 3,
  parameter int RP  = sdbrw_pkg::RP_CK,
  parameter int RAS = sdbrw_pkg::RAS_CK,
  parameter int RC  = sdbrw_pkg::RC_CK
) (
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic       ck,
  input wire logic [2:0] cmd,
  input wire logic [2:0] bank,
  input wire logic       ctrl_dq_oe,
  input wire logic       dev_dq_oe
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic       ck_q, rise, fall, iss;
  logic [7:0] col_q, col_d, rd_q, rd_d, act_q, act_d, pre_q, pre_d, db_q, db_d, wb_q, wb_d;
  logic [2:0] rdb_q, rdb_d, actb_q, actb_d, preb_q, preb_d;
  // ages count link clock rises since the event and saturate, so early commands pass
  function automatic logic [7:0] age(input logic [7:0] a, input logic hit);
    return hit ? 8'h00 : a + {7'h00, rise && a != 8'hff};
  endfunction
  always_comb begin
    rise   = ck & ~ck_q;
    fall   = ~ck & ck_q;
    iss    = fall && cmd != sdbrw_pkg::CMD_NOP;
    col_d  = age(col_q, iss && (cmd == sdbrw_pkg::CMD_RD || cmd == sdbrw_pkg::CMD_WR));
    rd_d   = age(rd_q, iss && cmd == sdbrw_pkg::CMD_RD);
    act_d  = age(act_q, iss && cmd == sdbrw_pkg::CMD_ACT);
    pre_d  = age(pre_q, iss && cmd == sdbrw_pkg::CMD_PRE);
    rdb_d  = (iss && cmd == sdbrw_pkg::CMD_RD) ? bank : rdb_q;
    actb_d = (iss && cmd == sdbrw_pkg::CMD_ACT) ? bank : actb_q;
    preb_d = (iss && cmd == sdbrw_pkg::CMD_PRE) ? bank : preb_q;
    db_d   = dev_dq_oe ? db_q + {7'h00, rise} : 8'h00;
    wb_d   = ctrl_dq_oe ? wb_q + {7'h00, rise} : 8'h00;
  end
  // registers only; ages start long ago
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      {ck_q, db_q, wb_q, rdb_q, actb_q, preb_q} <= '0;
      {col_q, rd_q, act_q, pre_q} <= {4{sdbrw_pkg::AGE_RST}};
    end else begin
      {ck_q, db_q, wb_q, rdb_q, actb_q, preb_q} <= {ck, db_d, wb_d, rdb_d, actb_d, preb_d};
      {col_q, rd_q, act_q, pre_q} <= {col_d, rd_d, act_d, pre_d};
    end
  end
  chk_col_gap: assert property (iss && (cmd == sdbrw_pkg::CMD_RD || cmd == sdbrw_pkg::CMD_WR)
    |-> col_q >= 8'd4) else $error("column commands too close");
  chk_rd_to_pre: assert property (iss && cmd == sdbrw_pkg::CMD_PRE && bank == rdb_q
    |-> rd_q >= AL + sdbrw_pkg::RTP_CK) else $error("precharge too soon after read");
  chk_act_to_pre: assert property (iss && cmd == sdbrw_pkg::CMD_PRE && bank == actb_q
    |-> act_q >= RAS) else $error("precharge too soon after activate");
  chk_reactivate: assert property (iss && cmd == sdbrw_pkg::CMD_ACT
    |-> (bank != preb_q || pre_q >= RP) && (bank != actb_q || act_q >= RC))
    else $error("activate too soon");
  chk_rd_latency: assert property ($rose(dev_dq_oe) |-> rd_q == AL + CL + 1)
    else $error("read data at wrong rise");
  chk_rd_len: assert property ($fell(dev_dq_oe) |-> db_q == 8'd4 || db_q == 8'd8)
    else $error("read burst length wrong");
  chk_wr_len: assert property ($fell(ctrl_dq_oe) |-> wb_q == 8'd4 || wb_q == 8'd8)
    else $error("write burst length wrong");
  chk_cmd_stable: assert property (!fall |-> $stable(cmd))
    else $error("command moved off a clock fall");
  chk_one_driver: assert property (!(dev_dq_oe && ctrl_dq_oe))
    else $error("both ends drive data");
endmodule

// file: tb_top.sv
// self-checking bench joining controller and device over the link
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys = 1'b0, rst = 1'b1, rq_v = 1'b0, rq_chop = 1'b0, rq_ap = 1'b0;
  logic [2:0]  rq_cmd = 3'h0, rq_bank = 3'h0;
  logic [15:0] rq_row = 16'h0000;
  logic [9:0]  rq_col = 10'h000;
  logic [63:0] rq_wd = 64'h0, w0, w1, rd_data;
  logic [1:0]  mode = sdbrw_pkg::MODE_OTF;
  logic [3:0]  add_lat = 4'h1, cas_lat = 4'h3;
  logic        req_ready, req_refused, rd_valid, busy;
  logic [7:0]  open_banks;
  int          bad_count = 0, total_checks = 0, cycles = 0;
  integer      seed = 32'h1dd3_3a0e;
  logic        e_ref_q[$];
  logic [63:0] e_dat_q[$], e_msk_q[$];
  always #5 clk_sys = ~clk_sys;
  sdbrw_link_if sdbrw_link_if_i ();
  sdbrw_ctrl sdbrw_ctrl_i (.CLK_SYS(clk_sys), .RST(rst), .LINK(sdbrw_link_if_i), .REQ_VALID(rq_v),
    .REQ_CMD(rq_cmd), .REQ_BANK(rq_bank), .REQ_ROW(rq_row), .REQ_COL(rq_col), .REQ_CHOP(rq_chop),
    .REQ_AUTO_PRE(rq_ap), .REQ_WDATA(rq_wd), .MODE_BURST(mode), .ADD_LAT(add_lat), .WR_LAT(4'h4),
    .REQ_READY(req_ready), .REQ_REFUSED(req_refused), .RD_VALID(rd_valid), .RD_DATA(rd_data));
  sdbrw_dev sdbrw_dev_i (.CLK_SYS(clk_sys), .RST(rst), .LINK(sdbrw_link_if_i), .MODE_BURST(mode),
    .ADD_LAT(add_lat), .CAS_LAT(cas_lat), .OPEN_BANKS(open_banks), .BUSY(busy));
  sdbrw_chk #(.AL(1), .CL(3)) sdbrw_chk_i (.CLK_SYS(clk_sys), .RST(rst),
    .ck(sdbrw_link_if_i.ck), .cmd(sdbrw_link_if_i.cmd), .bank(sdbrw_link_if_i.bank),
    .ctrl_dq_oe(sdbrw_link_if_i.ctrl_dq_oe), .dev_dq_oe(sdbrw_link_if_i.dev_dq_oe));
  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // device open-row flags and busy flag against the expected picture
  task automatic check_open(input logic [8:0] e);
    total_checks++;
    if ({busy, open_banks} !== e) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, {busy, open_banks}, e);
    end
  endtask
  // one request, held until taken; reads and refusals leave a note for the monitor
  task automatic req(input logic [2:0] c, input logic [2:0] b, input logic [9:0] col,
                     input logic ch, input logic ap, input logic [63:0] wd,
                     input logic er, input logic [63:0] ed, input logic [63:0] em);
    @(posedge clk_sys);
    while (req_ready !== 1'b1) @(posedge clk_sys);
    {rq_v, rq_cmd, rq_bank, rq_col, rq_chop, rq_ap, rq_wd} <= {1'b1, c, b, col, ch, ap, wd};
    rq_row <= 16'($random(seed));
    if (er || c == sdbrw_pkg::CMD_RD) begin
      e_ref_q.push_back(er);
      e_dat_q.push_back(ed);
      e_msk_q.push_back(em);
    end
    @(posedge clk_sys);
    while (req_ready !== 1'b1) @(posedge clk_sys);
    rq_v <= 1'b0;
  endtask
  // monitor: oldest note against each answer
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
    if (rd_valid === 1'b1 || req_refused === 1'b1) begin
      total_checks++;
      if (e_ref_q.size() == 0 || req_refused !== e_ref_q[0] ||
          ((rd_data ^ e_dat_q[0]) & e_msk_q[0]) !== 64'h0) begin
        bad_count++;
        $display("mismatch at %0t got %h expected %h", $time, rd_data, e_dat_q[0]);
      end
      if (e_ref_q.size() > 0) begin
        void'(e_ref_q.pop_front());
        void'(e_dat_q.pop_front());
        void'(e_msk_q.pop_front());
      end
    end
  end
  // main sequence: refusals, bursts of both lengths, nibble wrap, auto precharge
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    w0 = {$random(seed), $random(seed)};
    w1 = {$random(seed), $random(seed)};
    req(sdbrw_pkg::CMD_ACT, 1, 0, 0, 0, 0, 0, 0, 0);
    req(sdbrw_pkg::CMD_PRE, 1, 0, 0, 0, 0, 1, 0, 0);
    req(sdbrw_pkg::CMD_ACT, 1, 0, 0, 0, 0, 1, 0, 0);
    req(sdbrw_pkg::CMD_WR, 1, 0, 0, 0, w0, 0, 0, 0);
    req(sdbrw_pkg::CMD_RD, 1, 0, 0, 0, 0, 0, w0, '1);
    req(sdbrw_pkg::CMD_RD, 1, 4, 1, 0, 0, 0, w0 >> 32, 64'hffff_ffff);
    req(sdbrw_pkg::CMD_RD, 1, 5, 1, 0, 0, 0, {w0[39:32], w0[63:40]}, 64'hffff_ffff);
    req(sdbrw_pkg::CMD_WR, 1, 0, 1, 1, w1, 0, 0, 0);
    req(sdbrw_pkg::CMD_RD, 1, 0, 0, 0, 0, 1, 0, 0);
    check_open(9'h000);
    repeat (400) @(posedge clk_sys);
    req(sdbrw_pkg::CMD_ACT, 1, 0, 0, 0, 0, 0, 0, 0);
    req(sdbrw_pkg::CMD_RD, 1, 0, 0, 0, 0, 0, {w0[63:32], w1[31:0]}, '1);
    @(posedge clk_sys);
    while (req_ready !== 1'b1) @(posedge clk_sys);
    mode <= sdbrw_pkg::MODE_FIXED8;
    req(sdbrw_pkg::CMD_RD, 1, 0, 1, 0, 0, 0, {w0[63:32], w1[31:0]}, '1);
    @(posedge clk_sys);
    while (req_ready !== 1'b1) @(posedge clk_sys);
    mode <= sdbrw_pkg::MODE_FIXED4;
    req(sdbrw_pkg::CMD_RD, 1, 0, 0, 0, 0, 0, {w0[63:32], w1[31:0]}, 64'hffff_ffff);
    req(sdbrw_pkg::CMD_RD, 2, 0, 0, 0, 0, 1, 0, 0);
    req(sdbrw_pkg::CMD_PRE, 1, 0, 0, 0, 0, 0, 0, 0);
    for (int i = 0; i < 3000 && e_ref_q.size() > 0; i++) @(posedge clk_sys);
    repeat (40) @(posedge clk_sys);
    check_open(9'h000);
    if (e_ref_q.size() > 0) begin
      bad_count++;
    end
    conclude();
  end
endmodule
